// ==== irl_chk.sv ====
// concurrent checks on the pins between the core control end and its partner
`timescale 1ns/100ps
`default_nettype none
module irl_chk
	import irl_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic nonmaskable_req_n,
	input wire logic power_on_reset_n,
	input wire logic snoop_bus_req_n,
	input wire logic xfer_bus_grant_n,
	input wire logic hiprio_xfer_bus_grant_n,
	input wire logic snoop_bus_grant_n,
	input wire logic hiprio_snoop_bus_grant_n,
	input wire logic bus_owned_n,
	input wire logic [IRL_BE_W-1:0] byte_lane_en_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic cacheable_n,
	input wire logic access_kind_flag,
	input wire logic burst_n,
	input wire logic burst_start_n,
	input wire logic final_beat_n,
	input wire logic stop_mode_flag,
	input wire logic light_sleep_flag
);
	// not cleared by i_srst, so lows held through it still count
	logic [3:0] low_cnt_r = 4'h0;
	logic [3:0] low_cnt_nxt;

	always_comb begin
		low_cnt_nxt = 4'h0;
		if (!power_on_reset_n) begin
			low_cnt_nxt = (low_cnt_r == 4'hf) ? 4'hf : low_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge i_mclk) begin
		low_cnt_r <= low_cnt_nxt;
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	sequence nmi_low_s;
		$fell(nonmaskable_req_n);
	endsequence
	sequence nmi_back_s;
		##1 nonmaskable_req_n;
	endsequence
	sequence idle_pins_s;
		bus_owned_n && (byte_lane_en_n == IRL_BE_IDLE) && read_strobe_n && write_strobe_n && cacheable_n
			&& (access_kind_flag == IRL_KIND_IDLE) && burst_n && burst_start_n && final_beat_n
			&& !stop_mode_flag && !light_sleep_flag;
	endsequence

	reset_pins_idle_a: assert property (low_cnt_r >= IRL_COLD_MIN |-> idle_pins_s)
		else $error("bus outputs not idle in cold reset");
	reset_grants_off_a: assert property (low_cnt_r >= IRL_COLD_MIN |-> xfer_bus_grant_n && hiprio_xfer_bus_grant_n
		&& snoop_bus_grant_n && hiprio_snoop_bus_grant_n)
		else $error("grant still active in cold reset");
	cold_hold_len_a: assert property ($rose(power_on_reset_n) |-> low_cnt_r >= IRL_COLD_MIN)
		else $error("cold reset released too early");
	nmi_one_pulse_a: assert property (nmi_low_s |-> nmi_back_s)
		else $error("nmi line not returned high");
	flags_exclusive_a: assert property (!(stop_mode_flag && light_sleep_flag))
		else $error("halt and doze flags both high");
	lowpower_no_read_a: assert property ((stop_mode_flag || light_sleep_flag)
		&& ($past(stop_mode_flag) || $past(light_sleep_flag)) |-> read_strobe_n)
		else $error("read strobe active in low power");
	halt_no_snoop_a: assert property (stop_mode_flag && $past(stop_mode_flag)
		|-> !$fell(snoop_bus_grant_n) && !$fell(hiprio_snoop_bus_grant_n))
		else $error("snoop granted during halt");
	snoop_grant_drop_a: assert property (!snoop_bus_grant_n && snoop_bus_req_n |=> snoop_bus_grant_n)
		else $error("snoop grant kept after withdrawal");
endmodule : irl_chk
`default_nettype wire

// ==== irl_core_ctrl.sv ====
// core-side interrupt intake, cold reset, endian strap and halt/doze control
`timescale 1ns/100ps
`default_nettype none
module irl_core_ctrl
	import irl_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_srst,
	irl_if.dev bus,
	input wire logic i_sleep_exec,
	input wire logic [IRL_PC_W-1:0] i_sleep_pc,
	input wire logic i_lowpower_sel,
	input wire logic [IRL_IRQ_W-1:0] i_irq_mask,
	input wire logic i_global_irq_enable,
	input wire logic i_bus_busy,
	input wire logic i_wbuf_pending,
	input wire logic i_mem_rd,
	input wire logic i_mem_wr,
	input wire logic i_mem_cacheable,
	input wire logic i_mem_kind,
	input wire logic i_mem_burst,
	input wire logic i_mem_bstart,
	input wire logic i_mem_last,
	input wire logic [IRL_BE_W-1:0] i_mem_be,
	input wire logic [IRL_ADDR_W-1:0] i_mem_addr,
	input wire logic [IRL_DATA_W-1:0] i_mem_wdata,
	output logic o_irq_req,
	output logic [IRL_IRQ_W-1:0] o_irq_pending_field,
	output logic o_nmi_take,
	output logic o_warm_reset,
	output logic o_reset_exc,
	output logic o_core_init,
	output logic o_core_stop,
	output logic o_pipe_keep,
	output logic o_bus_abort,
	output logic o_big_endian,
	output logic o_wake,
	output logic o_wake_to_handler,
	output logic [IRL_PC_W-1:0] o_exception_return_pc,
	output logic o_snoop_inval,
	output logic [IRL_ADDR_W-1:0] o_snoop_addr
);
	typedef struct packed {
		irl_mode_e mode;
		irl_own_e own;
		logic in_rst;
		logic [3:0] cold_cnt;
		logic nmi_prev;
		logic nmi_pend;
		logic big_endian;
		logic irq_req;
		logic [IRL_IRQ_W-1:0] ip;
		logic rst_exc;
		logic nmi_take;
		logic abort;
		logic wake;
		logic wake_hdl;
		logic [IRL_PC_W-1:0] sleep_pc;
		logic [IRL_PC_W-1:0] exception_return_pc;
		logic snoop_inval;
		logic [IRL_ADDR_W-1:0] snoop_addr;
		logic [IRL_ADDR_W-1:0] addr;
		logic [IRL_DATA_W-1:0] wdata;
		logic [IRL_BE_W-1:0] be_n;
		logic rd_n;
		logic wr_n;
		logic cache_n;
		logic kind;
		logic burst_n;
		logic bstart_n;
		logic last_n;
	} irl_dev_s;

	irl_dev_s s_r;
	irl_dev_s s_nxt;
	logic [IRL_IRQ_W-1:0] irq_lvl;
	logic nmi_edge;
	logic cold;
	logic warm;
	logic snoop_ok;
	logic wake_any;
	logic to_handler;
	logic drive_ok;

	always_comb begin
		s_nxt = s_r;
		irq_lvl = ~bus.ext_irq_lines_n;
		cold = ~bus.power_on_reset_n;
		warm = ~bus.warm_reset_n;
		nmi_edge = s_r.nmi_prev & ~bus.nonmaskable_req_n;
		snoop_ok = (s_r.mode != MODE_HALT);
		wake_any = (|irq_lvl) | s_r.nmi_pend | nmi_edge | warm | cold;
		to_handler = s_r.nmi_pend | nmi_edge | warm | cold | ((|(irq_lvl & i_irq_mask)) & i_global_irq_enable);
		s_nxt.rst_exc = 1'b0;
		s_nxt.nmi_take = 1'b0;
		s_nxt.abort = 1'b0;
		s_nxt.wake = 1'b0;
		s_nxt.snoop_inval = 1'b0;
		s_nxt.nmi_prev = bus.nonmaskable_req_n;
		s_nxt.ip = irq_lvl;
		if (!cold) begin
			s_nxt.cold_cnt = 4'h0;
		end else if (s_r.cold_cnt != IRL_COLD_MIN) begin
			s_nxt.cold_cnt = s_r.cold_cnt + 4'h1;
		end
		s_nxt.irq_req = (s_r.mode == MODE_RUN) && !s_r.in_rst && (|(irq_lvl & i_irq_mask)) && i_global_irq_enable;
		if (s_r.mode == MODE_RUN && !s_r.in_rst && !i_bus_busy && s_r.own == OWN_CORE && s_r.nmi_pend) begin
			s_nxt.nmi_take = 1'b1;
			s_nxt.nmi_pend = 1'b0;
		end
		// ownership only handed over between bus ops
		case (s_r.own)
			OWN_CORE: begin
				if (!i_bus_busy && !s_r.in_rst) begin
					if (!bus.hiprio_snoop_bus_req_n && snoop_ok) begin
						s_nxt.own = OWN_HSNOOP;
					end else if (!bus.hiprio_xfer_bus_req_n) begin
						s_nxt.own = OWN_HXFER;
					end else if (!bus.snoop_bus_req_n && snoop_ok) begin
						s_nxt.own = OWN_SNOOP;
					end else if (!bus.xfer_bus_req_n) begin
						s_nxt.own = OWN_XFER;
					end
				end
			end
			OWN_XFER: begin
				if (bus.xfer_bus_req_n) begin
					s_nxt.own = OWN_CORE;
				end
			end
			OWN_HXFER: begin
				if (bus.hiprio_xfer_bus_req_n) begin
					s_nxt.own = OWN_CORE;
				end
			end
			OWN_SNOOP: begin
				if (bus.snoop_bus_req_n) begin
					s_nxt.own = OWN_CORE;
				end
			end
			OWN_HSNOOP: begin
				if (bus.hiprio_snoop_bus_req_n) begin
					s_nxt.own = OWN_CORE;
				end
			end
			default: begin
				s_nxt.own = OWN_CORE;
			end
		endcase
		if ((s_r.own == OWN_SNOOP || s_r.own == OWN_HSNOOP) && !bus.snoop_strobe_n) begin
			s_nxt.snoop_inval = 1'b1;
			s_nxt.snoop_addr = bus.snoop_addr;
		end
		case (s_r.mode)
			MODE_RUN: begin
				// no entry while a wake cause stands
				if (i_sleep_exec && !wake_any && !s_r.in_rst) begin
					s_nxt.sleep_pc = i_sleep_pc;
					s_nxt.mode = i_lowpower_sel ? MODE_DOZE_PEND : MODE_HALT_PEND;
				end
			end
			MODE_HALT_PEND, MODE_DOZE_PEND: begin
				// wait for op end and snoop master return
				if (wake_any) begin
					s_nxt.mode = MODE_RUN;
				end else if (!i_bus_busy && s_r.own != OWN_SNOOP && s_r.own != OWN_HSNOOP) begin
					s_nxt.mode = (s_r.mode == MODE_DOZE_PEND) ? MODE_DOZE : MODE_HALT;
				end
			end
			MODE_HALT, MODE_DOZE: begin
				if (wake_any) begin
					s_nxt.mode = MODE_RUN;
					s_nxt.wake = 1'b1;
					s_nxt.wake_hdl = to_handler;
					s_nxt.exception_return_pc = s_r.sleep_pc + IRL_PC_STEP;
				end
			end
			default: begin
				s_nxt.mode = MODE_RUN;
			end
		endcase
		if (nmi_edge) begin
			s_nxt.nmi_pend = 1'b1;
		end
		if (s_r.in_rst && !cold) begin
			s_nxt.in_rst = 1'b0;
			s_nxt.rst_exc = 1'b1;
			// strap taken on one edge only
			s_nxt.big_endian = bus.byte_order_select;
		end
		if (s_nxt.cold_cnt == IRL_COLD_MIN) begin
			s_nxt.in_rst = 1'b1;
			s_nxt.abort = i_bus_busy && !s_r.in_rst;
			s_nxt.own = OWN_CORE;
			s_nxt.mode = MODE_RUN;
			s_nxt.nmi_pend = 1'b0;
			s_nxt.irq_req = 1'b0;
			s_nxt.nmi_take = 1'b0;
		end
		// write buffer drains in low power
		drive_ok = !s_nxt.in_rst && s_nxt.own == OWN_CORE
			&& (s_r.mode == MODE_RUN || s_r.mode == MODE_HALT_PEND || s_r.mode == MODE_DOZE_PEND
			|| (i_mem_wr && i_wbuf_pending));
		// idle values in reset, under another master, and in halt or doze unless the write buffer drains
		if (drive_ok) begin
			s_nxt.addr = i_mem_addr;
			s_nxt.wdata = i_mem_wdata;
			s_nxt.be_n = ~i_mem_be;
			// only the write buffer may drain in halt or doze, never a read
			s_nxt.rd_n = ~i_mem_rd | (s_r.mode == MODE_HALT) | (s_r.mode == MODE_DOZE);
			s_nxt.wr_n = ~i_mem_wr;
			s_nxt.cache_n = ~i_mem_cacheable;
			s_nxt.kind = i_mem_kind;
			s_nxt.burst_n = ~i_mem_burst;
			s_nxt.bstart_n = ~i_mem_bstart;
			s_nxt.last_n = ~i_mem_last;
		end else begin
			s_nxt.be_n = IRL_BE_IDLE;
			s_nxt.rd_n = IRL_STROBE_IDLE;
			s_nxt.wr_n = IRL_STROBE_IDLE;
			s_nxt.cache_n = IRL_STROBE_IDLE;
			s_nxt.kind = IRL_KIND_IDLE;
			s_nxt.burst_n = IRL_STROBE_IDLE;
			s_nxt.bstart_n = IRL_STROBE_IDLE;
			s_nxt.last_n = IRL_STROBE_IDLE;
		end
	end

	// module reset puts the core in the reset state until cold reset is seen released
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			s_r <= '0;
			s_r.mode <= MODE_RUN;
			s_r.own <= OWN_CORE;
			s_r.in_rst <= 1'b1;
			s_r.nmi_prev <= 1'b1;
			s_r.big_endian <= IRL_ENDIAN_RST;
			s_r.be_n <= IRL_BE_IDLE;
			s_r.rd_n <= IRL_STROBE_IDLE;
			s_r.wr_n <= IRL_STROBE_IDLE;
			s_r.cache_n <= IRL_STROBE_IDLE;
			s_r.kind <= IRL_KIND_IDLE;
			s_r.burst_n <= IRL_STROBE_IDLE;
			s_r.bstart_n <= IRL_STROBE_IDLE;
			s_r.last_n <= IRL_STROBE_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.xfer_bus_grant_n = (s_r.own != OWN_XFER);
	assign bus.hiprio_xfer_bus_grant_n = (s_r.own != OWN_HXFER);
	assign bus.snoop_bus_grant_n = (s_r.own != OWN_SNOOP);
	assign bus.hiprio_snoop_bus_grant_n = (s_r.own != OWN_HSNOOP);
	assign bus.bus_owned_n = !(s_r.own == OWN_CORE && !s_r.in_rst);
	assign bus.addr_out = s_r.addr;
	assign bus.wdata_out = s_r.wdata;
	assign bus.byte_lane_en_n = s_r.be_n;
	assign bus.read_strobe_n = s_r.rd_n;
	assign bus.write_strobe_n = s_r.wr_n;
	assign bus.cacheable_n = s_r.cache_n;
	assign bus.access_kind_flag = s_r.kind;
	assign bus.burst_n = s_r.burst_n;
	assign bus.burst_start_n = s_r.bstart_n;
	assign bus.final_beat_n = s_r.last_n;
	assign bus.stop_mode_flag = (s_r.mode == MODE_HALT) && !s_r.in_rst;
	assign bus.light_sleep_flag = (s_r.mode == MODE_DOZE) && !s_r.in_rst;
	assign o_irq_req = s_r.irq_req;
	assign o_irq_pending_field = s_r.ip;
	assign o_nmi_take = s_r.nmi_take;
	assign o_warm_reset = ~bus.warm_reset_n;
	assign o_reset_exc = s_r.rst_exc;
	// control regs, caches, pipeline held in init
	assign o_core_init = s_r.in_rst;
	assign o_core_stop = s_r.in_rst || s_r.mode == MODE_HALT || s_r.mode == MODE_DOZE;
	assign o_pipe_keep = (s_r.mode == MODE_DOZE);
	assign o_bus_abort = s_r.abort;
	assign o_big_endian = s_r.big_endian;
	assign o_wake = s_r.wake;
	assign o_wake_to_handler = s_r.wake_hdl;
	assign o_exception_return_pc = s_r.exception_return_pc;
	assign o_snoop_inval = s_r.snoop_inval;
	assign o_snoop_addr = s_r.snoop_addr;
endmodule : irl_core_ctrl
`default_nettype wire

// ==== irl_if.sv ====
// pin bundle between the core control end and its interrupt, reset and bus-master partners
`timescale 1ns/100ps
`default_nettype none
interface irl_if;
	import irl_pkg::*;
	logic [IRL_IRQ_W-1:0] ext_irq_lines_n;
	logic nonmaskable_req_n;
	logic power_on_reset_n;
	logic warm_reset_n;
	logic byte_order_select;
	logic xfer_bus_req_n;
	logic hiprio_xfer_bus_req_n;
	logic snoop_bus_req_n;
	logic hiprio_snoop_bus_req_n;
	logic snoop_strobe_n;
	logic [IRL_ADDR_W-1:0] snoop_addr;
	logic xfer_bus_grant_n;
	logic hiprio_xfer_bus_grant_n;
	logic snoop_bus_grant_n;
	logic hiprio_snoop_bus_grant_n;
	logic bus_owned_n;
	logic [IRL_ADDR_W-1:0] addr_out;
	logic [IRL_DATA_W-1:0] wdata_out;
	logic [IRL_BE_W-1:0] byte_lane_en_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic cacheable_n;
	logic access_kind_flag;
	logic burst_n;
	logic burst_start_n;
	logic final_beat_n;
	logic stop_mode_flag;
	logic light_sleep_flag;

	modport dev (
		input ext_irq_lines_n, nonmaskable_req_n, power_on_reset_n, warm_reset_n, byte_order_select,
		input xfer_bus_req_n, hiprio_xfer_bus_req_n, snoop_bus_req_n, hiprio_snoop_bus_req_n,
		input snoop_strobe_n, snoop_addr,
		output xfer_bus_grant_n, hiprio_xfer_bus_grant_n, snoop_bus_grant_n, hiprio_snoop_bus_grant_n,
		output bus_owned_n, addr_out, wdata_out, byte_lane_en_n, read_strobe_n, write_strobe_n,
		output cacheable_n, access_kind_flag, burst_n, burst_start_n, final_beat_n,
		output stop_mode_flag, light_sleep_flag
	);
	modport host (
		output ext_irq_lines_n, nonmaskable_req_n, power_on_reset_n, warm_reset_n, byte_order_select,
		output xfer_bus_req_n, hiprio_xfer_bus_req_n, snoop_bus_req_n, hiprio_snoop_bus_req_n,
		output snoop_strobe_n, snoop_addr,
		input xfer_bus_grant_n, hiprio_xfer_bus_grant_n, snoop_bus_grant_n, hiprio_snoop_bus_grant_n,
		input bus_owned_n, addr_out, wdata_out, byte_lane_en_n, read_strobe_n, write_strobe_n,
		input cacheable_n, access_kind_flag, burst_n, burst_start_n, final_beat_n,
		input stop_mode_flag, light_sleep_flag
	);
endinterface : irl_if
`default_nettype wire

// ==== irl_partner.sv ====
// partner end: interrupt sources, reset generator and external bus masters
`timescale 1ns/100ps
`default_nettype none
module irl_partner
	import irl_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_srst,
	irl_if.host bus,
	input wire logic [IRL_IRQ_W-1:0] i_irq_set,
	input wire logic [IRL_IRQ_W-1:0] i_irq_clear,
	input wire logic i_nmi_fire,
	input wire logic i_power_on,
	input wire logic i_warm_reset,
	input wire logic i_big_endian,
	input wire logic i_xfer_req,
	input wire logic i_hxfer_req,
	input wire logic i_snoop_req,
	input wire logic i_hsnoop_req,
	input wire logic i_snoop_write,
	input wire logic [IRL_ADDR_W-1:0] i_snoop_addr,
	output logic o_nmi_busy,
	output logic o_cold_busy,
	output logic [3:0] o_grants,
	output logic o_halted,
	output logic o_dozing
);
	typedef struct packed {
		logic [IRL_IRQ_W-1:0] irq_hold;
		logic nmi_n;
		logic cold_n;
		logic [3:0] cold_cnt;
		logic warm_n;
		logic endian;
		logic [3:0] req_n;
		logic snoop_n;
		logic [IRL_ADDR_W-1:0] snoop_addr;
	} irl_host_s;

	irl_host_s s_r;
	irl_host_s s_nxt;
	logic snoop_granted;

	always_comb begin
		s_nxt = s_r;
		snoop_granted = !bus.snoop_bus_grant_n || !bus.hiprio_snoop_bus_grant_n;
		s_nxt.irq_hold = (s_r.irq_hold & ~i_irq_clear) | i_irq_set;
		// one low cycle, then high before the next
		if (!s_r.nmi_n) begin
			s_nxt.nmi_n = 1'b1;
		end else if (i_nmi_fire) begin
			s_nxt.nmi_n = 1'b0;
		end
		if (i_power_on) begin
			s_nxt.cold_n = 1'b0;
			s_nxt.cold_cnt = 4'h0;
		end else if (!s_r.cold_n) begin
			s_nxt.cold_cnt = s_r.cold_cnt + 4'h1;
			if (s_nxt.cold_cnt == IRL_COLD_MIN) begin
				s_nxt.cold_n = 1'b1;
			end
		end
		s_nxt.warm_n = ~i_warm_reset;
		s_nxt.endian = i_big_endian;
		s_nxt.req_n = ~{i_hsnoop_req, i_snoop_req, i_hxfer_req, i_xfer_req};
		// strobe only when a snoop-type grant is seen, else the address is not looked at
		s_nxt.snoop_n = !(i_snoop_write && snoop_granted);
		s_nxt.snoop_addr = i_snoop_addr;
	end

	// module reset starts a power-on cold reset pulse
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			s_r <= '0;
			s_r.nmi_n <= 1'b1;
			s_r.cold_n <= 1'b0;
			s_r.warm_n <= 1'b1;
			s_r.endian <= IRL_ENDIAN_RST;
			s_r.req_n <= 4'hf;
			s_r.snoop_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.ext_irq_lines_n = ~s_r.irq_hold;
	assign bus.nonmaskable_req_n = s_r.nmi_n;
	assign bus.power_on_reset_n = s_r.cold_n;
	assign bus.warm_reset_n = s_r.warm_n;
	assign bus.byte_order_select = s_r.endian;
	assign bus.xfer_bus_req_n = s_r.req_n[0];
	assign bus.hiprio_xfer_bus_req_n = s_r.req_n[1];
	assign bus.snoop_bus_req_n = s_r.req_n[2];
	assign bus.hiprio_snoop_bus_req_n = s_r.req_n[3];
	assign bus.snoop_strobe_n = s_r.snoop_n;
	assign bus.snoop_addr = s_r.snoop_addr;
	assign o_nmi_busy = ~s_r.nmi_n;
	assign o_cold_busy = ~s_r.cold_n;
	assign o_grants = ~{bus.hiprio_snoop_bus_grant_n, bus.snoop_bus_grant_n,
		bus.hiprio_xfer_bus_grant_n, bus.xfer_bus_grant_n};
	assign o_halted = bus.stop_mode_flag;
	assign o_dozing = bus.light_sleep_flag;
endmodule : irl_partner
`default_nettype wire

// ==== irl_pkg.sv ====
// shared constants and types for the interrupt, reset and low-power control ends
package irl_pkg;
	localparam int IRL_IRQ_W = 6;
	localparam int IRL_ADDR_W = 36;
	localparam int IRL_DATA_W = 64;
	localparam int IRL_BE_W = 8;
	localparam int IRL_PC_W = 64;
	// consecutive asserted cold-reset samples before the reset state
	localparam logic [3:0] IRL_COLD_MIN = 4'hc;
	localparam logic [IRL_PC_W-1:0] IRL_PC_STEP = 64'h4;
	localparam logic [IRL_BE_W-1:0] IRL_BE_IDLE = 8'hff;
	localparam logic IRL_STROBE_IDLE = 1'b1;
	localparam logic IRL_KIND_IDLE = 1'b1;
	localparam logic IRL_FLAG_RST = 1'b0;
	localparam logic IRL_ENDIAN_RST = 1'b1;

	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_HALT_PEND,
		MODE_DOZE_PEND,
		MODE_HALT,
		MODE_DOZE
	} irl_mode_e;

	typedef enum logic [2:0] {
		OWN_CORE,
		OWN_XFER,
		OWN_HXFER,
		OWN_SNOOP,
		OWN_HSNOOP
	} irl_own_e;
endpackage : irl_pkg

// ==== tb.sv ====
// bench joining the core control end to its partner end over the pin bundle
`timescale 1ns/100ps
`default_nettype none
module tb;
	import irl_pkg::*;
	logic i_mclk = 1'h0;
	logic i_srst = 1'h1;
	logic sl = 1'h0, lps = 1'h0, en = 1'h0, busy = 1'h0, wbp = 1'h0, rd = 1'h0, wr = 1'h0;
	logic nmf = 1'h0, pon = 1'h0, wrs = 1'h0, be_sel = 1'h1, xr = 1'h0, hxr = 1'h0, sr = 1'h0, hsr = 1'h0, swr = 1'h0;
	logic [5:0] msk = 6'h00, iset = 6'h00, iclr = 6'h00;
	logic [63:0] pc = 64'h0;
	logic [35:0] sa = 36'h0;
	logic irq, nmi_t, wrst, rexc, cinit, cstop, pkeep, abrt, bige, wk, wkh, sinv;
	logic [5:0] pend;
	logic [63:0] exception_return_pc;
	logic [35:0] saddr;
	logic [3:0] gr;
	logic nbsy, cbsy, hlt, dz;
	int error_cnt = 0;
	int n_compared = 0;

	irl_if bus_if ();
	irl_core_ctrl irl_core_ctrl_inst (.i_mclk(i_mclk), .i_srst(i_srst), .bus(bus_if.dev), .i_sleep_exec(sl),
		.i_sleep_pc(pc), .i_lowpower_sel(lps), .i_irq_mask(msk), .i_global_irq_enable(en), .i_bus_busy(busy),
		.i_wbuf_pending(wbp), .i_mem_rd(rd), .i_mem_wr(wr), .i_mem_cacheable(wr), .i_mem_kind(rd), .i_mem_burst(wr),
		.i_mem_bstart(rd), .i_mem_last(wr), .i_mem_be({8{wr}}), .i_mem_addr(sa), .i_mem_wdata(pc), .o_irq_req(irq),
		.o_irq_pending_field(pend), .o_nmi_take(nmi_t), .o_warm_reset(wrst), .o_reset_exc(rexc), .o_core_init(cinit),
		.o_core_stop(cstop), .o_pipe_keep(pkeep), .o_bus_abort(abrt), .o_big_endian(bige), .o_wake(wk),
		.o_wake_to_handler(wkh), .o_exception_return_pc(exception_return_pc), .o_snoop_inval(sinv), .o_snoop_addr(saddr));
	irl_partner irl_partner_inst (.i_mclk(i_mclk), .i_srst(i_srst), .bus(bus_if.host), .i_irq_set(iset),
		.i_irq_clear(iclr), .i_nmi_fire(nmf), .i_power_on(pon), .i_warm_reset(wrs), .i_big_endian(be_sel),
		.i_xfer_req(xr), .i_hxfer_req(hxr), .i_snoop_req(sr), .i_hsnoop_req(hsr), .i_snoop_write(swr),
		.i_snoop_addr(sa), .o_nmi_busy(nbsy), .o_cold_busy(cbsy), .o_grants(gr), .o_halted(hlt), .o_dozing(dz));
	irl_chk irl_chk_inst (.i_mclk(i_mclk), .i_srst(i_srst), .nonmaskable_req_n(bus_if.nonmaskable_req_n),
		.power_on_reset_n(bus_if.power_on_reset_n), .snoop_bus_req_n(bus_if.snoop_bus_req_n),
		.xfer_bus_grant_n(bus_if.xfer_bus_grant_n), .hiprio_xfer_bus_grant_n(bus_if.hiprio_xfer_bus_grant_n),
		.snoop_bus_grant_n(bus_if.snoop_bus_grant_n), .hiprio_snoop_bus_grant_n(bus_if.hiprio_snoop_bus_grant_n),
		.bus_owned_n(bus_if.bus_owned_n), .byte_lane_en_n(bus_if.byte_lane_en_n),
		.read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
		.cacheable_n(bus_if.cacheable_n), .access_kind_flag(bus_if.access_kind_flag), .burst_n(bus_if.burst_n),
		.burst_start_n(bus_if.burst_start_n), .final_beat_n(bus_if.final_beat_n),
		.stop_mode_flag(bus_if.stop_mode_flag), .light_sleep_flag(bus_if.light_sleep_flag));

	always #4 i_mclk = ~i_mclk;

	task cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask : cyc

	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge i_mclk);
		s = 1'h0;
	endtask : pulse

	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task results;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	task automatic t_cold(input logic e, input logic b);
		int k;
		be_sel = e;
		busy = b;
		pulse(pon);
		chk("cold busy", cbsy, 1'h1);
		for (k = 0; k < (b ? 30 : 12) && abrt !== 1'h1; k++) cyc(1);
		if (b) chk("abort at", k > 11, 1'h1);
		chk("core init", cinit, 1'h1);
		busy = 1'h0;
		for (k = 0; k < 30 && rexc !== 1'h1; k++) cyc(1);
		chk("reset exc", rexc, 1'h1);
		chk("endian", bige, e);
		chk("cold done", cbsy, 1'h0);
		be_sel = !e;
		cyc(3);
		chk("endian kept", bige, e);
	endtask : t_cold

	task automatic t_nmi;
		int k;
		int n;
		busy = 1'h1;
		pulse(nmf);
		chk("nmi busy", nbsy, 1'h1);
		cyc(4);
		chk("nmi held", nmi_t, 1'h0);
		busy = 1'h0;
		n = 0;
		for (k = 0; k < 8; k++) begin
			cyc(1);
			n = n + (nmi_t === 1'h1);
		end
		chk("nmi count", n, 1);
	endtask : t_nmi

	task t_irq;
		iset = 6'h04;
		msk = 6'h04;
		en = 1'h1;
		cyc(1);
		iset = 6'h00;
		cyc(2);
		chk("pending", pend, 6'h04);
		chk("irq req", irq, 1'h1);
		en = 1'h0;
		cyc(2);
		chk("irq off", irq, 1'h0);
		iclr = 6'h04;
		cyc(1);
		iclr = 6'h00;
		cyc(2);
		chk("pending live", pend, 6'h00);
	endtask : t_irq

	task automatic t_sleep(input logic lp);
		int k;
		int n;
		lps = lp;
		busy = 1'h1;
		pc = 64'h1000;
		pulse(sl);
		cyc(3);
		chk("early flag", bus_if.stop_mode_flag | bus_if.light_sleep_flag, 1'h0);
		busy = 1'h0;
		cyc(3);
		chk("halt flag", bus_if.stop_mode_flag, !lp);
		chk("doze flag", bus_if.light_sleep_flag, lp);
		chk("pipe keep", pkeep, lp);
		chk("core stop", cstop, 1'h1);
		chk("partner view", {hlt, dz}, {!lp, lp});
		wbp = 1'h1;
		wr = 1'h1;
		rd = 1'h1;
		cyc(1);
		chk("drain", bus_if.write_strobe_n, 1'h0);
		chk("read idle", bus_if.read_strobe_n, 1'h1);
		chk("drain addr", bus_if.addr_out, sa);
		wbp = 1'h0;
		wr = 1'h0;
		rd = 1'h0;
		sr = 1'h1;
		cyc(4);
		chk("snoop grant", gr[2], lp);
		sa = 36'h9abc0;
		pulse(swr);
		n = 0;
		for (k = 0; k < 6; k++) begin
			cyc(1);
			n = n + (sinv === 1'h1);
		end
		chk("snoops", n, lp);
		if (lp) chk("snoop addr", saddr, sa);
		sr = 1'h0;
		cyc(2);
		chk("snoop drop", gr[2], 1'h0);
		xr = 1'h1;
		cyc(3);
		chk("xfer grant", gr[0], 1'h1);
		xr = 1'h0;
		cyc(2);
		// masked line resumes, nmi enters the handler
		msk = 6'h00;
		en = 1'h1;
		iset = {5'h00, !lp};
		nmf = lp;
		cyc(1);
		iset = 6'h00;
		nmf = 1'h0;
		for (k = 0; k < 8 && wk !== 1'h1; k++) cyc(1);
		chk("wake", wk, 1'h1);
		chk("to handler", wkh, lp);
		chk("return pc", exception_return_pc, 64'h1004);
		cyc(1);
		chk("flags off", bus_if.stop_mode_flag | bus_if.light_sleep_flag, 1'h0);
		iclr = 6'h01;
		cyc(1);
		iclr = 6'h00;
		cyc(3);
	endtask : t_sleep

	task t_block;
		iset = 6'h02;
		msk = 6'h02;
		cyc(3);
		iset = 6'h00;
		pulse(sl);
		cyc(1);
		chk("run kept", irq, 1'h1);
		cyc(3);
		chk("blocked", {bus_if.stop_mode_flag, bus_if.light_sleep_flag, cstop}, 3'h0);
		iclr = 6'h02;
		cyc(1);
		iclr = 6'h00;
		wrs = 1'h1;
		cyc(2);
		chk("warm level", wrst, 1'h1);
		wrs = 1'h0;
		cyc(2);
	endtask : t_block

	initial begin
		cyc(20);
		i_srst = 1'h0;
		t_cold(1'h0, 1'h0);
		t_nmi();
		t_irq();
		t_sleep(1'h0);
		t_sleep(1'h1);
		t_block();
		t_cold(1'h1, 1'h1);
		results();
	end

	// run is about 155 cycles, so this leaves a wide margin
	initial begin
		#20000;
		error_cnt++;
		results();
	end
endmodule : tb
`default_nettype wire
